// [rtl/drive_operation_mode_selector.sv]
// Mode selection logic for a motor drive: standard, full-closed or fork control.
// Assumes a host on a plain register port and synchronous terminal inputs.
//
// Our own choices: the register offsets and strobed register access.
`include "mode_sel_params.svh"
`timescale 1ns/1ps
`default_nettype none
module drive_operation_mode_selector (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    // Register port
    input  wire mode_sel_pkg::bus_req_t  busReq,
    output var  logic [15:0]             rdata_r,
    // Terminal and drive state
    input  wire mode_sel_pkg::term_in_t  termIn,
    input  wire logic                    driveRunning,
    input  wire logic                    networkOperation,
    // Resolved mode
    output var  mode_sel_pkg::mode_out_t modeOut_r
);
    import mode_sel_pkg::*;

    // Stored parameters
    logic [15:0] logisticsModeSelect_r;          // Mode selection
    logic [15:0] rampReferenceFrequency_r;       // Ramp reference frequency
    logic [15:0] referenceTravelSpeed_r;         // Travel speed at reference
    logic [15:0] secondMotorSetting_r;           // Second motor, 9999 none
    logic [15:0] secondAccelTime_r;              // Second accel time
    logic [15:0] secondDecelTime_r;              // Second decel time
    logic [15:0] controlMethodSelect_r;          // First control method
    logic [15:0] secondControlMethodSelect_r;    // Second control method
    logic [15:0] commCommandSource_r;            // Command source
    logic [15:0] commSpeedSource_r;              // Speed source
    logic [15:0] operationModeParam_r;           // Operation mode
    logic [15:0] terminalFunctionAssign_r [`TERM_COUNT]; // Terminal functions

    // Sampled inputs
    term_in_t    termIn_r;                       // Registered terminals
    logic        running_r;                      // Registered run state
    logic        netOp_r;                        // Registered network mode

    // Resolved mode state
    op_mode_t    target;                         // Requested mode
    op_mode_t    mode_r;                         // Applied mode
    logic        pending_r;                      // Change waiting on stop

    // In-range check shared by the range-limited parameters
    function automatic logic inRange(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        inRange = (v >= lo) && (v <= hi);
    endfunction : inRange

    // Accepted control methods for the dedicated mode
    function automatic logic methodOk(input logic [15:0] m);
        methodOk = (m == `CM_VECTOR) || (m == `CM_SENSORLESS) || (m == `CM_FLUX) || (m == `CM_VF);
    endfunction : methodOk

    // Parameter writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            logisticsModeSelect_r       <= `RST_MODE_SELECT;
            rampReferenceFrequency_r    <= `RST_REF_FREQ;
            referenceTravelSpeed_r      <= `RST_REF_SPEED;
            secondMotorSetting_r        <= `RST_SECOND_MOTOR;
            secondAccelTime_r           <= `RST_SECOND_ACCEL;
            secondDecelTime_r           <= `RST_SECOND_DECEL;
            controlMethodSelect_r       <= `RST_CTRL_METHOD;
            secondControlMethodSelect_r <= `RST_CTRL_METHOD;
            commCommandSource_r         <= `RST_ZERO;
            commSpeedSource_r           <= `RST_ZERO;
            operationModeParam_r        <= `RST_ZERO;
        end else if (busReq.wr) begin
            unique case (busReq.addr)
                `ADDR_MODE_SELECT: begin
                    // Only codes 0..2 are stored
                    if (busReq.wdata <= `SEL_TEST) begin
                        logisticsModeSelect_r <= busReq.wdata;
                    end
                end
                `ADDR_REF_FREQ: begin
                    if (inRange(busReq.wdata, `FREQ_MIN, `FREQ_MAX)) begin
                        rampReferenceFrequency_r <= busReq.wdata;
                    end
                end
                `ADDR_REF_SPEED: begin
                    // Range or the unset marker
                    if (inRange(busReq.wdata, `SPEED_MIN, `SPEED_MAX) || busReq.wdata == `UNSET_9999) begin
                        referenceTravelSpeed_r <= busReq.wdata;
                    end
                end
                `ADDR_SECOND_MOTOR:  secondMotorSetting_r        <= busReq.wdata;
                `ADDR_SECOND_ACCEL:  secondAccelTime_r           <= busReq.wdata;
                `ADDR_SECOND_DECEL:  secondDecelTime_r           <= busReq.wdata;
                `ADDR_CTRL_METHOD:   controlMethodSelect_r       <= busReq.wdata;
                `ADDR_CTRL_METHOD2:  secondControlMethodSelect_r <= busReq.wdata;
                `ADDR_CMD_SOURCE:    commCommandSource_r         <= busReq.wdata;
                `ADDR_SPEED_SOURCE:  commSpeedSource_r           <= busReq.wdata;
                `ADDR_OPMODE:        operationModeParam_r        <= busReq.wdata;
                default: begin
                    // Terminal assignments and read-only slots
                end
            endcase
        end
    end

    // Terminal function assignments share one indexed window at the top
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < `TERM_COUNT; i++) begin
                terminalFunctionAssign_r[i] <= `RST_ZERO;
            end
        end else if (busReq.wr && busReq.addr == `ADDR_TERM_ASSIGN) begin
            // Upper byte of data picks the terminal, lower byte the code
            if (busReq.wdata[15:8] < 8'(`TERM_COUNT)) begin
                terminalFunctionAssign_r[busReq.wdata[11:8]] <= {8'h00, busReq.wdata[7:0]};
            end
        end
    end

    // Input sampling
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            termIn_r  <= '0;
            running_r <= 1'b0;
            netOp_r   <= 1'b0;
        end else begin
            termIn_r  <= termIn;
            running_r <= driveRunning;
            netOp_r   <= networkOperation;
        end
    end

    // Condition and target mode resolution
    logic forkAssigned;                           // Some terminal carries fork select
    logic forkActive;                             // Fork input as seen by the logic
    logic dedicatedOk;                            // All enable conditions met
    always_comb begin
        forkAssigned = 1'b0;
        for (int i = 0; i < `TERM_COUNT; i++) begin
            if (terminalFunctionAssign_r[i] == `TERM_FORK_CODE) begin
                forkAssigned = 1'b1;
            end
        end
        forkActive  = forkAssigned && termIn_r.forkSelectInput;
        dedicatedOk = (logisticsModeSelect_r == `SEL_ENABLE)
                   && (referenceTravelSpeed_r != `UNSET_9999)
                   && termIn_r.logisticsModeRequest
                   && (methodOk(controlMethodSelect_r) || methodOk(secondControlMethodSelect_r))
                   && netOp_r && (commCommandSource_r == `RST_ZERO)
                   && (commSpeedSource_r == `RST_ZERO);
        if (!dedicatedOk) begin
            target = MODE_STANDARD;
        end else if (secondMotorSetting_r != `UNSET_9999 && forkActive) begin
            target = MODE_FORK;
        end else begin
            target = MODE_FULL_CLOSED;
        end
    end

    // Applied mode: changes only while stopped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_r    <= MODE_STANDARD;
            pending_r <= 1'b0;
        end else if (!running_r) begin
            mode_r    <= target;
            pending_r <= 1'b0;
        end else begin
            pending_r <= (target != mode_r);
        end
    end

    // Registered mode outputs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            modeOut_r <= '0;
        end else begin
            modeOut_r.mode          <= mode_r;
            // Second bank on fork control or either second input
            modeOut_r.secondBank    <= (mode_r == MODE_FORK) || forkActive
                                    || termIn_r.secondFunctionInput;
            modeOut_r.rampAlt       <= (mode_r == MODE_FULL_CLOSED) && termIn_r.rampTimeSelectInput;
            modeOut_r.testOperation <= (logisticsModeSelect_r == `SEL_TEST);
            modeOut_r.panelAllowed  <= (operationModeParam_r == `OPMODE_SWITCHOVER);
            modeOut_r.forkDecelTime <= (secondDecelTime_r == `UNSET_9999) ? secondAccelTime_r
                                                                         : secondDecelTime_r;
        end
    end

    // Status word
    logic [15:0] statusWord;                      // Live mode status
    always_comb begin
        statusWord = '0;
        statusWord[`ST_LOGISTICS]    = (modeOut_r.mode != MODE_STANDARD);
        statusWord[`ST_FORK]         = (modeOut_r.mode == MODE_FORK);
        statusWord[`ST_SECOND_BANK]  = modeOut_r.secondBank;
        statusWord[`ST_RAMP_ALT]     = modeOut_r.rampAlt;
        statusWord[`ST_TEST]         = modeOut_r.testOperation;
        statusWord[`ST_PENDING]      = pending_r;
        statusWord[`ST_PANEL_ALLOWED] = modeOut_r.panelAllowed;
    end

    // Read data, one cycle after the strobe; zero otherwise
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (busReq.rd) begin
            unique case (busReq.addr)
                `ADDR_MODE_SELECT:  rdata_r <= logisticsModeSelect_r;
                `ADDR_REF_FREQ:     rdata_r <= rampReferenceFrequency_r;
                `ADDR_REF_SPEED:    rdata_r <= referenceTravelSpeed_r;
                `ADDR_SECOND_MOTOR: rdata_r <= secondMotorSetting_r;
                `ADDR_SECOND_ACCEL: rdata_r <= secondAccelTime_r;
                `ADDR_SECOND_DECEL: rdata_r <= secondDecelTime_r;
                `ADDR_CTRL_METHOD:  rdata_r <= controlMethodSelect_r;
                `ADDR_CTRL_METHOD2: rdata_r <= secondControlMethodSelect_r;
                `ADDR_CMD_SOURCE:   rdata_r <= commCommandSource_r;
                `ADDR_SPEED_SOURCE: rdata_r <= commSpeedSource_r;
                `ADDR_OPMODE:       rdata_r <= operationModeParam_r;
                `ADDR_TERM_ASSIGN:  rdata_r <= {15'h0000, forkAssigned};
                `ADDR_STATUS:       rdata_r <= statusWord;
                `ADDR_FORK_DECEL:   rdata_r <= modeOut_r.forkDecelTime;
                default:            rdata_r <= '0;
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    // Checks

    // Applied mode frozen while the drive runs
    mode_hold_run_a: assert property (@(posedge clk_sys) disable iff (rst)
        running_r && $past(running_r) |-> mode_r == $past(mode_r))
        else $error("mode changed while running");

    // Pending flag drops once the drive is stopped
    pending_stop_a: assert property (@(posedge clk_sys) disable iff (rst)
        !running_r |=> !pending_r)
        else $error("pending left set while stopped");

    // Standard mode applied when conditions fail
    std_when_off_a: assert property (@(posedge clk_sys) disable iff (rst)
        !dedicatedOk && !running_r |=> mode_r == MODE_STANDARD)
        else $error("standard mode not applied");

    // Unset travel speed blocks the dedicated mode
    speed_unset_a: assert property (@(posedge clk_sys) disable iff (rst)
        referenceTravelSpeed_r == `UNSET_9999 |-> !dedicatedOk)
        else $error("dedicated mode with unset speed");

    // Mode select must hold the enable code
    select_one_a: assert property (@(posedge clk_sys) disable iff (rst)
        logisticsModeSelect_r != `SEL_ENABLE |-> target == MODE_STANDARD)
        else $error("dedicated mode without select 1");

    // Request input must be high
    request_needed_a: assert property (@(posedge clk_sys) disable iff (rst)
        !termIn_r.logisticsModeRequest |-> target == MODE_STANDARD)
        else $error("dedicated mode without request");

    // Fork needs a second motor and an assigned input
    fork_second_a: assert property (@(posedge clk_sys) disable iff (rst)
        target == MODE_FORK |-> secondMotorSetting_r != `UNSET_9999 && forkAssigned)
        else $error("fork without second motor");

    // Unset decel falls back to the accel time
    decel_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
        secondDecelTime_r == `UNSET_9999 && $stable(secondAccelTime_r) |=> modeOut_r.forkDecelTime == $past(secondAccelTime_r))
        else $error("fork decel not taken from accel");

    // Second-function input lights bank two
    bank_two_a: assert property (@(posedge clk_sys) disable iff (rst)
        termIn_r.secondFunctionInput |=> modeOut_r.secondBank)
        else $error("second bank missing");

    // Network operation is required
    network_need_a: assert property (@(posedge clk_sys) disable iff (rst)
        !netOp_r |-> target == MODE_STANDARD)
        else $error("dedicated mode outside network operation");

    // Neither method register accepted: no dedicated mode
    method_need_a: assert property (@(posedge clk_sys) disable iff (rst)
        !methodOk(controlMethodSelect_r) && !methodOk(secondControlMethodSelect_r) |-> !dedicatedOk)
        else $error("dedicated mode with wrong method");

    // Nonzero command or speed source keeps standard mode
    source_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        commCommandSource_r != `RST_ZERO || commSpeedSource_r != `RST_ZERO |-> target == MODE_STANDARD)
        else $error("dedicated mode with nonzero source");

    // Test code raises the test flag
    test_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
        logisticsModeSelect_r == `SEL_TEST |=> modeOut_r.testOperation)
        else $error("test operation flag missing");

    // Stored reference frequency stays in range
    freq_range_a: assert property (@(posedge clk_sys) disable iff (rst)
        inRange(rampReferenceFrequency_r, `FREQ_MIN, `FREQ_MAX))
        else $error("reference frequency out of range");

    // Stored travel speed in range or unset
    speed_range_a: assert property (@(posedge clk_sys) disable iff (rst)
        inRange(referenceTravelSpeed_r, `SPEED_MIN, `SPEED_MAX) || referenceTravelSpeed_r == `UNSET_9999)
        else $error("travel speed out of range");

    // Fork control runs on bank two
    fork_bank_a: assert property (@(posedge clk_sys) disable iff (rst)
        mode_r == MODE_FORK |=> modeOut_r.secondBank)
        else $error("fork without second bank");

    // No assigned terminal means no fork control
    fork_unassigned_a: assert property (@(posedge clk_sys) disable iff (rst)
        !forkAssigned |-> target != MODE_FORK)
        else $error("fork without assigned terminal");

    // Alternate ramps only under full-closed control
    ramp_full_a: assert property (@(posedge clk_sys) disable iff (rst)
        mode_r != MODE_FULL_CLOSED |=> !modeOut_r.rampAlt)
        else $error("alternate ramp outside full-closed");

    // Switchover code allows panel operation
    panel_switch_a: assert property (@(posedge clk_sys) disable iff (rst)
        operationModeParam_r == `OPMODE_SWITCHOVER |=> modeOut_r.panelAllowed)
        else $error("panel operation not allowed");

    // Mode output follows the applied mode one edge later
    mode_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> modeOut_r.mode == $past(mode_r))
        else $error("mode output not registered");
endmodule : drive_operation_mode_selector
`default_nettype wire

// [rtl/mode_sel_params.svh]
// Constants for the drive operation mode selector: offsets, fields, resets, codes.
// Assumes inclusion by bare name from the package and the design file.
`ifndef MODE_SEL_PARAMS_SVH
`define MODE_SEL_PARAMS_SVH
// Register indices (word addresses on the plain port)
`define ADDR_MODE_SELECT      4'h0
`define ADDR_REF_FREQ         4'h1
`define ADDR_REF_SPEED        4'h2
`define ADDR_SECOND_MOTOR     4'h3
`define ADDR_SECOND_ACCEL     4'h4
`define ADDR_SECOND_DECEL     4'h5
`define ADDR_CTRL_METHOD      4'h6
`define ADDR_CTRL_METHOD2     4'h7
`define ADDR_CMD_SOURCE       4'h8
`define ADDR_SPEED_SOURCE     4'h9
`define ADDR_OPMODE           4'ha
`define ADDR_TERM_ASSIGN      4'hb
`define ADDR_STATUS           4'hc
`define ADDR_FORK_DECEL       4'hd
// Reset values
`define RST_MODE_SELECT       16'h0000
`define RST_REF_FREQ          16'h003c
`define RST_REF_SPEED         16'h270f
`define RST_SECOND_MOTOR      16'h270f
`define RST_SECOND_ACCEL      16'h0005
`define RST_SECOND_DECEL      16'h270f
`define RST_CTRL_METHOD       16'h0014
`define RST_ZERO              16'h0000
// Codes and limits
`define UNSET_9999            16'h270f
`define SEL_ENABLE            16'h0001
`define SEL_TEST              16'h0002
`define CM_VECTOR             16'h0000
`define CM_SENSORLESS         16'h000a
`define CM_FLUX               16'h0014
`define CM_VF                 16'h0028
`define OPMODE_SWITCHOVER     16'h0006
`define TERM_FORK_CODE        16'h006c
`define FREQ_MIN              16'h0001
`define FREQ_MAX              16'h024e
`define SPEED_MIN             16'h0001
`define SPEED_MAX             16'h0258
`define TERM_COUNT            12
// Status bit positions
`define ST_LOGISTICS          0
`define ST_FORK               1
`define ST_SECOND_BANK        2
`define ST_RAMP_ALT           3
`define ST_TEST               4
`define ST_PENDING            5
`define ST_PANEL_ALLOWED      6
`endif

// [rtl/mode_sel_pkg.sv]
// Types for the drive operation mode selector.
// Assumes the params header sits beside it.
`default_nettype none
`include "mode_sel_params.svh"
package mode_sel_pkg;
    // Resolved operating mode
    typedef enum logic [1:0] {
        MODE_STANDARD    = 2'b00,
        MODE_FULL_CLOSED = 2'b01,
        MODE_FORK        = 2'b10
    } op_mode_t;
    // Register bus request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;
    // Discrete terminal inputs
    typedef struct packed {
        logic logisticsModeRequest;
        logic forkSelectInput;
        logic rampTimeSelectInput;
        logic secondFunctionInput;
    } term_in_t;
    // Resolved mode outputs
    typedef struct packed {
        op_mode_t mode;
        logic     secondBank;
        logic     rampAlt;
        logic     testOperation;
        logic     panelAllowed;
        logic [15:0] forkDecelTime;
    } mode_out_t;
endpackage : mode_sel_pkg
`default_nettype wire

// [test/term_host_model.sv]
// Host and terminal model: drives terminal levels, drive state and network mode.
// Assumes the bench sets the wanted levels; the block sees them one edge later.
`timescale 1ns/1ps
`default_nettype none
module term_host_model (
    // Clock
    input  wire logic                   clk_sys,
    // Wanted levels from the bench
    input  wire mode_sel_pkg::term_in_t wantTerm,
    input  wire logic                   wantRun,
    input  wire logic                   wantNet,
    // Levels at the block
    output var  mode_sel_pkg::term_in_t termIn,
    output var  logic                   driveRunning,
    output var  logic                   networkOperation
);
    import mode_sel_pkg::*;
    // Terminals change only on clock edges, like debounced inputs
    always @(posedge clk_sys) begin
        termIn <= wantTerm;
        driveRunning <= wantRun;
        networkOperation <= wantNet;
    end
endmodule : term_host_model
`default_nettype wire

// [test/drive_operation_mode_selector_tb.sv]
// Bench for the mode selector: register model, mode model, random configs.
// Assumes the params header and package are compiled before it.
`include "mode_sel_params.svh"
`timescale 1ns/1ps
`default_nettype none
module drive_operation_mode_selector_tb;
    import mode_sel_pkg::*;
    logic        clk_sys = 1'b0;    // System clock
    logic        rst = 1'b1;        // Synchronous reset
    bus_req_t    busReq = '0;       // Register port request
    logic [15:0] rdata_r;           // Read data
    term_in_t    termIn;            // Terminals at the block
    term_in_t    wantTerm = '0;     // Terminals asked of the model
    logic        driveRunning;      // Drive state at the block
    logic        networkOperation;  // Network mode at the block
    logic        wantRun = 1'b0;    // Wanted drive state
    logic        wantNet = 1'b0;    // Wanted network mode
    mode_out_t   modeOut_r;         // Resolved mode
    int          n_fail = 0;        // Mismatches
    int          cmp_count = 0;     // Comparisons
    logic [31:0] lfsrState = 32'h9d8b;  // Random source state
    logic [15:0] mr [16];           // Model of the parameter registers
    logic        fAsg = 1'b0;       // Model: fork input assigned to a terminal
    logic [15:0] cmTab [8] = '{16'h0000, 16'h000a, 16'h0014, 16'h0028, 16'h0001, 16'h0003, 16'h0014, 16'h0000};
    logic [31:0] r;                 // Current random word

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    drive_operation_mode_selector drive_operation_mode_selector_inst (
        .clk_sys(clk_sys), .rst(rst), .busReq(busReq), .rdata_r(rdata_r), .termIn(termIn),
        .driveRunning(driveRunning), .networkOperation(networkOperation), .modeOut_r(modeOut_r));
    term_host_model term_host_model_inst (
        .clk_sys(clk_sys), .wantTerm(wantTerm), .wantRun(wantRun), .wantNet(wantNet),
        .termIn(termIn), .driveRunning(driveRunning), .networkOperation(networkOperation));

    // Register read comparison
    task automatic chk_rd(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_rd

    // Mode output comparison
    task automatic chk_out(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_out

    // Next random word
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Accepted control method codes
    function automatic logic cm_ok(input logic [15:0] c);
        return c == 16'h0000 || c == 16'h000a || c == 16'h0014 || c == 16'h0028;
    endfunction : cm_ok

    // One write cycle; the model keeps only values in range
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        busReq.wr <= 1'b0;
        case (a)
            4'h0: if (d <= 16'h0002) mr[a] = d;
            4'h1: if (d >= 16'h0001 && d <= 16'h024e) mr[a] = d;
            4'h2: if ((d >= 16'h0001 && d <= 16'h0258) || d == 16'h270f) mr[a] = d;
            4'hb: fAsg = d[7:0] == 8'h6c;
            default: if (a < 4'hb) mr[a] = d;
        endcase
    endtask : wr_reg

    // One read cycle; data stand in the next cycle only
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clk_sys);
        busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        busReq.rd <= 1'b0;
        #1;
        chk_rd($sformatf("reg %h", a), e & m, rdata_r & m);
    endtask : rd_chk

    // Let the mode settle, then compare outputs and status with the model
    task automatic check_mode();
        logic ded, frk, sb;
        logic [15:0] st, mk, ob;
        repeat (8) @(posedge clk_sys);
        #1;
        ded = mr[0] == 16'h0001 && mr[2] != 16'h270f && wantTerm.logisticsModeRequest && wantNet
              && (cm_ok(mr[6]) || cm_ok(mr[7])) && mr[8] == 16'h0000 && mr[9] == 16'h0000;
        frk = ded && mr[3] != 16'h270f && wantTerm.forkSelectInput && fAsg;
        sb = (wantTerm.forkSelectInput && fAsg) || wantTerm.secondFunctionInput;
        mk = 16'hffff;
        // Alternate ramp flag must stay low outside full-closed control
        st = {9'h0, mr[10] == 16'h0006, 1'b0, mr[0] == 16'h0002,
              ded && !frk && wantTerm.rampTimeSelectInput, sb, frk, ded};
        ob = {9'h0, modeOut_r.panelAllowed, 1'b0, modeOut_r.testOperation, modeOut_r.rampAlt, modeOut_r.secondBank, 2'b00};
        chk_out("mode", {14'h0, frk, ded && !frk}, {14'h0, modeOut_r.mode});
        chk_out("flags", st & mk & 16'h005c, ob & mk);
        chk_out("fork decel", mr[5] == 16'h270f ? mr[4] : mr[5], modeOut_r.forkDecelTime);
        rd_chk(`ADDR_STATUS, st, mk);
    endtask : check_mode

    // Print counts and verdict, then stop
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // Watchdog well beyond the expected two thousand cycles or so
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_fail++;
        final_report();
    end

    // Main sequence
    initial begin
        mr = '{default: 16'h0000};
        mr[1] = 16'h003c;
        mr[2] = 16'h270f;
        mr[3] = 16'h270f;
        mr[4] = 16'h0005;
        mr[5] = 16'h270f;
        mr[6] = 16'h0014;
        mr[7] = 16'h0014;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values and an unmapped address
        for (int a = 0; a < 11; a++) rd_chk(a[3:0], mr[a], 16'hffff);
        rd_chk(4'he, 16'h0000, 16'hffff);
        check_mode();
        // Out-of-range writes are dropped, upper limits accepted
        wr_reg(`ADDR_REF_FREQ, 16'h0000);
        wr_reg(`ADDR_REF_FREQ, 16'h024f);
        wr_reg(`ADDR_REF_FREQ, 16'h024e);
        wr_reg(`ADDR_REF_SPEED, 16'h0259);
        wr_reg(`ADDR_REF_SPEED, 16'h0258);
        wr_reg(`ADDR_MODE_SELECT, 16'h0003);
        wr_reg(`ADDR_MODE_SELECT, 16'h0001);
        for (int a = 0; a < 3; a++) rd_chk(a[3:0], mr[a], 16'hffff);
        // Fork requested but no terminal carries it: full-closed
        wr_reg(`ADDR_SECOND_MOTOR, 16'h0003);
        wantNet <= 1'b1;
        wantTerm <= '{logisticsModeRequest: 1'b1, forkSelectInput: 1'b1, default: 1'b0};
        check_mode();
        wr_reg(`ADDR_TERM_ASSIGN, 16'h036c);
        rd_chk(`ADDR_TERM_ASSIGN, 16'h0001, 16'h0001);
        check_mode();
        // Change while running is held back until the stop
        wantRun <= 1'b1;
        wantTerm.logisticsModeRequest <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rd_chk(`ADDR_STATUS, 16'h0023, 16'h0023);
        wantRun <= 1'b0;
        check_mode();
        // Random configurations
        for (int i = 0; i < 60; i++) begin
            lfsrState = lfsr_next(lfsrState);
            r = lfsrState;
            wantTerm <= term_in_t'(r[3:0] | {r[5], 3'b000});
            wantNet <= r[4] | r[5];
            wr_reg(`ADDR_MODE_SELECT, r[7:6] == 2'b00 ? 16'h0000 : (r[7:6] == 2'b01 ? 16'h0002 : 16'h0001));
            wr_reg(`ADDR_REF_SPEED, (r[8] & r[9]) ? 16'h270f : 16'h0064);
            wr_reg(`ADDR_SECOND_MOTOR, r[10] ? 16'h270f : 16'h0003);
            wr_reg(`ADDR_CTRL_METHOD, cmTab[r[13:11]]);
            wr_reg(`ADDR_CTRL_METHOD2, cmTab[r[16:14]]);
            wr_reg(`ADDR_CMD_SOURCE, {15'h0, r[17] & r[18]});
            wr_reg(`ADDR_SPEED_SOURCE, {15'h0, r[19] & r[20]});
            wr_reg(`ADDR_OPMODE, r[21] ? 16'h0006 : 16'h0000);
            wr_reg(`ADDR_SECOND_ACCEL, {8'h00, r[30:23]});
            wr_reg(`ADDR_SECOND_DECEL, r[22] ? 16'h270f : {8'h00, r[31:24]});
            check_mode();
        end
        final_report();
    end
endmodule : drive_operation_mode_selector_tb
`default_nettype wire
